// ===== design/ssm_sram.sv
// synchronous flow-through static memory core with suspend, select and read tap buffer
`timescale 1ns/1ps
`default_nettype none

module ssm_sram
  import ssm_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  // memory bus inputs
  input  wire logic              clk_suspend_n,
  input  wire logic              advance_or_load,
  input  wire logic              read_write_n,
  input  wire logic              chip_select_low_a,
  input  wire logic              chip_select_low_b,
  input  wire logic              chip_select_high,
  input  wire logic [SSM_AW-1:0] addr,
  input  wire logic [SSM_NB-1:0] byte_write_strobes_n,
  input  wire logic              out_en_n,
  // data pins
  input  wire logic [SSM_DW-1:0] dq_i,
  output logic      [SSM_DW-1:0] dq_o,
  output logic                   dq_oe,
  // read tap stream
  output logic                   tap_valid,
  input  wire logic              tap_ready,
  output logic      [SSM_DW-1:0] tap_data,
  output logic                   tap_in_ready
);

  // selection decode
  function automatic logic ssm_selected(input logic lo_a, input logic lo_b, input logic hi);
    ssm_selected = ~lo_a & ~lo_b & hi;
  endfunction : ssm_selected

  logic                  step;
  ssm_cmd_s              cmd_q;
  ssm_cmd_s              cmd_d;
  logic [SSM_DW-1:0]     mem_q [SSM_WORDS];
  logic [SSM_DW-1:0]     mem_d [SSM_WORDS];
  logic [SSM_DW-1:0]     rd_word;
  logic [SSM_DW-1:0]     buf_q [SSM_BUF_D];
  logic [SSM_DW-1:0]     buf_d [SSM_BUF_D];
  logic [1:0]            cnt_q;
  logic [1:0]            cnt_d;
  logic                  push;
  logic                  pop;
  logic                  full;
  logic                  sel;
  logic [SSM_NB-1:0]     wr_lane;

  // a full tap buffer stalls the core like a suspended clock
  assign full         = (cnt_q == 2'(SSM_BUF_D));
  assign tap_in_ready = ~full;
  assign step         = clk_en & ~clk_suspend_n & tap_in_ready;

  // chip select decode
  assign sel = ssm_selected(chip_select_low_a, chip_select_low_b, chip_select_high);

  // flow-through read of the pending address
  assign rd_word = mem_q[cmd_q.addr];
  assign dq_o    = rd_word;
  assign dq_oe   = (cmd_q.op == SSM_READ) & ~out_en_n;

  // command pipeline
  always_comb
  begin
    cmd_d = cmd_q;
    if (step)
    begin
      if (!advance_or_load)
      begin
        if (sel)
        begin
          cmd_d.op   = read_write_n ? SSM_READ : SSM_WRITE;
          cmd_d.addr = addr;
          cmd_d.bw_n = byte_write_strobes_n;
        end
        else
        begin
          cmd_d.op = SSM_IDLE;
        end
      end
      // burst advance of the pending address
      else if (cmd_q.op != SSM_IDLE)
      begin
        cmd_d.addr = SSM_AW'(cmd_q.addr + 1'b1);
      end
    end
  end

  // pending command register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_q <= SSM_CMD_RST;
    end
    else
    begin
      cmd_q <= cmd_d;
    end
  end

  // per-lane write enables of the pending write
  genvar gb;
  generate
    for (gb = 0; gb < SSM_NB; gb++)
    begin : g_lane
      assign wr_lane[gb] = step & (cmd_q.op == SSM_WRITE) & ~cmd_q.bw_n[gb];
    end
  endgenerate

  // storage, written in the enabled cycle after the write load
  always_comb
  begin
    mem_d = mem_q;
    for (int b = 0; b < SSM_NB; b++)
    begin
      if (wr_lane[b])
      begin
        mem_d[cmd_q.addr][b*SSM_BYTE_W +: SSM_BYTE_W] =
          dq_i[b*SSM_BYTE_W +: SSM_BYTE_W];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SSM_WORDS; gi++)
    begin : g_mem
      always_ff @(posedge mclk)
      begin
        mem_q[gi] <= mem_d[gi];
      end
    end
  endgenerate

  // two-entry tap buffer of delivered read words
  assign push      = step & (cmd_q.op == SSM_READ);
  assign pop       = tap_valid & tap_ready;
  assign tap_valid = (cnt_q != SSM_CNT_RST);
  assign tap_data  = buf_q[0];

  always_comb
  begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (clk_en)
    begin
      // pop moves the second entry to the head
      if (pop)
      begin
        buf_d[0] = buf_q[1];
      end
      case ({push, pop})
        2'b10:
        begin
          buf_d[cnt_q[0]] = rd_word;
          cnt_d           = 2'(cnt_q + 2'h1);
        end
        2'b01:
        begin
          cnt_d = 2'(cnt_q - 2'h1);
        end
        2'b11:
        begin
          buf_d[cnt_q[1]] = rd_word;
        end
        2'b00:
        begin
          cnt_d = cnt_q;
        end
        default:
        begin
          cnt_d = cnt_q;
        end
      endcase
    end
  end

  // tap buffer fill count
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= SSM_CNT_RST;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // head and second entry of the tap buffer
  genvar gk;
  generate
    for (gk = 0; gk < SSM_BUF_D; gk++)
    begin : g_buf
      always_ff @(posedge mclk)
      begin
        buf_q[gk] <= buf_d[gk];
      end
    end
  endgenerate

endmodule : ssm_sram

`default_nettype wire

// ===== design/ssm_pkg.sv
// shared widths, reset values and command layout of the synchronous static memory
package ssm_pkg;

  localparam int unsigned SSM_AW      = 6;
  localparam int unsigned SSM_DW      = 36;
  localparam int unsigned SSM_NB      = 4;
  localparam int unsigned SSM_BYTE_W  = SSM_DW / SSM_NB;
  localparam int unsigned SSM_WORDS   = 1 << SSM_AW;
  localparam int unsigned SSM_BUF_D   = 2;
  localparam logic [1:0]  SSM_CNT_RST = 2'h0;
  localparam logic        SSM_VLD_RST = 1'h0;

  typedef enum logic [1:0]
  {
    SSM_IDLE  = 2'b00,
    SSM_READ  = 2'b01,
    SSM_WRITE = 2'b10
  } ssm_op_e;

  typedef struct packed
  {
    ssm_op_e             op;
    logic [SSM_AW-1:0]   addr;
    logic [SSM_NB-1:0]   bw_n;
  } ssm_cmd_s;

  localparam ssm_cmd_s SSM_CMD_RST = '{op: SSM_IDLE, addr: '0, bw_n: '1};

endpackage : ssm_pkg

// ===== tb/ssm_sram_asserts.sv
// port checker for the memory core
`timescale 1ns/1ps
`default_nettype none
module ssm_sram_asserts
  import ssm_pkg::*;
(
  input wire logic mclk, arst_n, clk_en, clk_suspend_n, advance_or_load, read_write_n,
  input wire logic chip_select_low_a, chip_select_low_b, chip_select_high, out_en_n,
  input wire logic dq_oe, tap_valid, tap_in_ready,
  input wire logic [SSM_DW-1:0] dq_o, tap_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire st = clk_en & ~clk_suspend_n & tap_in_ready;
  wire ld = st & ~advance_or_load;
  wire sl = ~chip_select_low_a & ~chip_select_low_b & chip_select_high;
  wire pu = st & dq_oe & ~tap_valid;
  sequence rd_s; ld && sl && read_write_n; endsequence
  dq_hold_a: assert property (!st && dq_oe |=> $stable(dq_o)) else $error("hold");
  rd_next_a: assert property (rd_s ##1 !out_en_n |-> dq_oe) else $error("late");
  rd_desel_a: assert property (rd_s ##1 (ld && !sl && !out_en_n) |-> dq_oe) else $error("rd desel");
  sus_keep_a: assert property (!st && dq_oe ##1 !out_en_n |-> dq_oe) else $error("keep");
  ds_float_a: assert property (ld && !sl |=> !dq_oe) else $error("desel");
  wr_float_a: assert property (ld && sl && !read_write_n |=> !dq_oe) else $error("wr");
  up_float_a: assert property ($rose(arst_n) |-> !dq_oe) else $error("up");
  tap_push_a: assert property (pu |=> tap_valid) else $error("push");
  tap_word_a: assert property (pu |=> tap_data == $past(dq_o)) else $error("tap");
endmodule : ssm_sram_asserts
bind ssm_sram ssm_sram_asserts u_chk (.*);
`default_nettype wire

// ===== tb/ssm_ctl_model.sv
// controller model
`timescale 1ns/1ps
`default_nettype none
module ssm_ctl_model
(
  input wire logic mclk, clk_en, clk_suspend_n, tap_in_ready, advance_or_load, read_write_n,
  input wire logic chip_select_low_a,
  input wire logic [35:0] wdata,
  output logic chip_select_low_b, chip_select_high,
  output logic [35:0] dq_i
);
  logic pend_q = 1'b0;
  wire step = clk_en & ~clk_suspend_n & tap_in_ready;
  assign chip_select_low_b = chip_select_low_a;
  assign chip_select_high = ~chip_select_low_a;
  always @(posedge mclk) if (step) pend_q <= ~advance_or_load & ~chip_select_low_a & ~read_write_n;
  assign dq_i = pend_q && step ? wdata : ~wdata;
endmodule : ssm_ctl_model
`default_nettype wire

// ===== tb/ssm_sram_test.sv
// directed bench for the memory core
`timescale 1ns/1ps
`default_nettype none
module ssm_sram_test;
  logic mclk = 0, arst_n = 0, clk_en = 1, clk_suspend_n = 1, advance_or_load = 1;
  logic read_write_n = 1, chip_select_low_a = 1, chip_select_low_b, chip_select_high;
  logic out_en_n = 0, tap_ready = 1, dq_oe, tap_valid, tap_in_ready;
  logic [5:0] addr = '0, la = '0;
  logic [3:0] byte_write_strobes_n = '0;
  logic [35:0] wdata = '0, dq_i, dq_o, tap_data;
  int fail_count = 0, n_compared = 0;
  ssm_sram dut (.*);
  ssm_ctl_model u_ctl (.*);
  initial forever #20 mclk = ~mclk;
  task chk(input logic [35:0] e, g, input string s);
    n_compared++;
    if (e !== g) fail_count++;
    if (e !== g) $display("[FAIL] %s exp %h got %h", s, e, g);
  endtask : chk
  task op(input logic [4:0] c, input logic [5:0] a, input logic oe, input logic [5:0] q);
    #1 chk(oe, dq_oe, "oe");
    if (oe) chk({6{q}}, dq_o, "dq");
    {tap_ready, clk_suspend_n, advance_or_load, read_write_n, chip_select_low_a} = c;
    {addr, wdata} = {a, {6{la}}};
    if (c[3:2] == 2'h0) la = a;
    @(posedge mclk);
  endtask : op
  task t_wr;
    op(5'h10, 1, 0, 0); op(5'h1A, 0, 0, 0);
    op(5'h10, 2, 0, 0); op(5'h10, 3, 0, 0);
    op(5'h13, 0, 0, 0);
    $display("write test done");
  endtask : t_wr
  task t_rd;
    op(5'h12, 1, 0, 0); op(5'h1A, 0, 1, 1);
    op(5'h1A, 0, 1, 1); op(5'h12, 2, 1, 1);
    op(5'h12, 3, 1, 2); op(5'h13, 0, 1, 3);
    op(5'h12, 1, 0, 0); op(5'h13, 0, 1, 1);
    $display("read test done");
  endtask : t_rd
  task t_tap;
    op(5'h13, 0, 0, 0); op(5'h02, 1, 0, 0);
    op(5'h02, 2, 1, 1); op(5'h02, 3, 1, 2);
    op(5'h03, 0, 1, 3);
    #1 chk(0, tap_in_ready, "full");
    chk({6{6'h1}}, tap_data, "tap");
    chk({6{6'h3}}, dq_o, "stall");
    $display("tap test done");
  endtask : t_tap
  task t_frz;
    op(5'h18, 0, 1, 3); op(5'h18, 0, 1, 3);
    #1 clk_en = 0;
    out_en_n = 1;
    la = 6'h05;
    byte_write_strobes_n = 4'hE;
    {tap_ready, clk_suspend_n, advance_or_load, read_write_n, chip_select_low_a} = 5'h10;
    {addr, wdata} = {6'h05, {6{6'h05}}};
    #1 chk(0, dq_oe, "oe_off");
    @(posedge mclk);
    #1 clk_en = 1;
    out_en_n = 0;
    #1 chk(1, dq_oe, "frz_oe");
    chk({6{6'h03}}, dq_o, "frz_dq");
    @(posedge mclk);
    op(5'h12, 5, 0, 0);
    #1 chk(36'h145, dq_o & 36'h1FF, "lane");
    byte_write_strobes_n = '0;
    {tap_ready, clk_suspend_n, advance_or_load, read_write_n, chip_select_low_a} = 5'h13;
    @(posedge mclk);
    $display("freeze test done");
  endtask : t_frz
  task end_of_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (10) @(posedge mclk);
    #1 arst_n = 1;
    @(posedge mclk);
    t_wr;
    t_rd;
    t_tap;
    t_frz;
    end_of_test;
  end
endmodule : ssm_sram_test
`default_nettype wire
